//--- hdl/fac_pkg.sv
// ==========================================================
// Clock ratio and alignment constants
package fac_pkg;

  // ========================================================
  // Register map of the system register block
  localparam logic [31:0] SYSTEM_REGISTER_BLOCK_BASE = 32'h40038000;
  localparam logic [31:0] CFG1_OFS = 32'h00000098;
  localparam logic [31:0] CFG2_OFS = 32'h0000009C;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] PROT_RESET = 32'hFFFFFFFF;

  // ========================================================
  // Field positions, config register 1
  localparam int MC_MULT_LSB = 0;
  localparam int MF_DIV_LSB = 4;
  localparam int APB_DIV_LSB = 8;
  // Field positions, config register 2
  localparam int IF0_DIV_LSB = 0;
  localparam int IF1_DIV_LSB = 4;
  localparam int ALIGN_ERR_BIT = 30;
  localparam int LOCK_BIT = 31;
  // Status bits are never stored from a write
  localparam logic [31:0] CFG2_STATUS = 32'hC0000000;

  // ========================================================
  // Timing: clk is 200 MHz; one main clock period is 24 ticks
  localparam int CLK_PERIOD_PS = 5000;
  localparam logic [11:0] MAIN_PER = 12'h018;
  // Common counter wraps at 2304 ticks, a multiple of every period
  localparam logic [11:0] WRAP_LAST = 12'h8FF;

  // ========================================================
  // Derived clock slots
  localparam int CK_MAIN = 0;
  localparam int CK_MC = 1;
  localparam int CK_MF = 2;
  localparam int CK_IF0 = 3;
  localparam int CK_IF1 = 4;
  localparam int CK_APB = 5;
  localparam int CK_NUM = 6;

  // ========================================================
  // Main clock divided by 1, 2, 4, 8, 16 or 32; codes above 5 clamp
  function automatic logic [11:0] fac_ratio_per(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > 3'h5) ? 3'h5 : sel;
    return MAIN_PER << s;
  endfunction

  // Memory controller period for x1, x2, x3, x4, x6, x8
  function automatic logic [11:0] fac_mc_per(input logic [2:0] sel);
    logic [11:0] p;
    unique case (sel)
      3'h0: p = 12'h018;
      3'h1: p = 12'h00C;
      3'h2: p = 12'h008;
      3'h3: p = 12'h006;
      3'h4: p = 12'h004;
      3'h5: p = 12'h003;
      default: p = 12'h018;
    endcase
    return p;
  endfunction

  // Memory fabric divider 1, 2, 3, 4, 6, 8, 12, 16
  function automatic logic [4:0] fac_mf_div(input logic [2:0] sel);
    logic [4:0] d;
    unique case (sel)
      3'h0: d = 5'h01;
      3'h1: d = 5'h02;
      3'h2: d = 5'h03;
      3'h3: d = 5'h04;
      3'h4: d = 5'h06;
      3'h5: d = 5'h08;
      3'h6: d = 5'h0C;
      3'h7: d = 5'h10;
    endcase
    return d;
  endfunction

  // Phase advance; an out-of-range phase after a change wraps too
  function automatic logic [11:0] fac_step(input logic [11:0] ph,
                                           input logic [11:0] per);
    return (ph >= per - 12'h001) ? 12'h000 : ph + 12'h001;
  endfunction

  // Clock is high in the first half of its period, rising at phase 0
  function automatic logic fac_level(input logic [11:0] ph,
                                     input logic [11:0] per);
    return ph < (per >> 1);
  endfunction

endpackage

//--- hdl/fac_link_if.sv
`timescale 1ns/1ps
// ==========================================================
// Link between the hard subsystem and the fabric logic
interface fac_link_if;
  // Clocks exported by the hard subsystem
  logic main_subsystem_clock;
  logic memory_fabric_if_clock;
  logic fabric_if0_clock;
  logic exported_if1_clock;
  // Lock and alignment mark from the hard subsystem
  logic exported_if1_lock;
  logic align_mark;
  // Slowest fabric subsystem clock fed back
  logic base_sync_clock;

  // Hard subsystem end
  modport dev (
    output main_subsystem_clock,
    output memory_fabric_if_clock,
    output fabric_if0_clock,
    output exported_if1_clock,
    output exported_if1_lock,
    output align_mark,
    input base_sync_clock
  );

  // Fabric end
  modport fab (
    input main_subsystem_clock,
    input memory_fabric_if_clock,
    input fabric_if0_clock,
    input exported_if1_clock,
    input exported_if1_lock,
    input align_mark,
    output base_sync_clock
  );
endinterface

//--- hdl/fac_fabric_end.sv
`timescale 1ns/1ps
// ==========================================================
// Fabric side: clocks the two fabric subsystems
module fac_fabric_end
  import fac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Ratio codes, must equal those held by the hard subsystem
  input wire logic [2:0] sub0_sel,
  input wire logic [2:0] sub1_sel,
  // Clocks and lock towards the user masters and slaves
  output logic sub0_clock,
  output logic sub1_clock,
  output logic user_lock,
  // Link
  fac_link_if.fab link
);

  // ========================================================
  // State
  typedef struct packed {
    logic [11:0] ph0;   // Phase of subsystem 0 clock
    logic [11:0] ph1;   // Phase of subsystem 1 clock
    logic ck0;          // Subsystem 0 clock level
    logic ck1;          // Subsystem 1 clock level
    logic base;         // Slowest clock, fed back
    logic lock;         // Copy of the exported lock
    logic [2:0] sel0;   // Subsystem 0 ratio code in force
    logic [2:0] sel1;   // Subsystem 1 ratio code in force
  } fac_fab_s;

  fac_fab_s st_reg;
  fac_fab_s st_next;
  logic [11:0] per0;
  logic [11:0] per1;

  // ========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    // New codes take effect at the mark, as in the hard subsystem R7
    if (link.align_mark) begin
      st_next.sel0 = sub0_sel;
      st_next.sel1 = sub1_sel;
    end
    // Ratios of 1..32 of the main clock R5 R7
    per0 = fac_ratio_per(st_next.sel0);
    per1 = fac_ratio_per(st_next.sel1);
    // The mark is phase 0 of every clock, so resync there R9
    if (link.align_mark) begin
      st_next.ph0 = 12'h001;
      st_next.ph1 = 12'h001;
    end else begin
      st_next.ph0 = fac_step(st_reg.ph0, per0);
      st_next.ph1 = fac_step(st_reg.ph1, per1);
    end
    // Levels are predicted one tick ahead to stay edge aligned
    st_next.ck0 = fac_level(st_next.ph0, per0);
    st_next.ck1 = fac_level(st_next.ph1, per1);
    // Larger code is the slower clock R8
    if (st_next.sel1 > st_next.sel0) begin
      st_next.base = st_next.ck1;
    end else begin
      st_next.base = st_next.ck0;
    end
    // Users take their lock from the exported lock R10
    st_next.lock = link.exported_if1_lock;
  end

  // ========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign sub0_clock = st_reg.ck0;
  assign sub1_clock = st_reg.ck1;
  assign user_lock = st_reg.lock;
  assign link.base_sync_clock = st_reg.base;

endmodule

//--- hdl/fac_clock_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// Hard subsystem clock conditioner: ratios, lock, config regs
//
// Behaviour
// R1: Main clock drives bus matrix, DMA, memories
// R2: Memory controller clock is x1,2,3,4,6,8
// R3: Memory fabric clock divides it 1..16
// R4: Interface clocks are main divided 1..32
// R5: Fabric subsystem clocks use ratios 1..32
// R6: Dedicated peripheral bus clock from main clock
// R7: Fabric clocks subsystems at configured frequency
// R8: Slowest fabric clock drives base input
// R9: Fabric clocks rise together with fastest
// R10: Lock high only while exported clock valid
// R11: Config loaded from flash, not changed later; code still lets writes change fields clear in the protect masks
// R12: Bus masters may read config and lock
// R13: Registers at 0x40038000 plus 0x98, 0x9C
// R14: All divided clocks share one counter
// R15: Reset registers; protected fields stay read-only
module fac_clock_ctrl
  import fac_pkg::*;
(
  // Clock and system register reset
  input wire logic clk,
  input wire logic sys_rst,
  // Flash configuration load at start-up
  input wire logic flash_load,
  input wire logic [31:0] flash_cfg1,
  input wire logic [31:0] flash_cfg2,
  input wire logic [31:0] flash_prot1,
  input wire logic [31:0] flash_prot2,
  // Register port
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  // Clocks kept inside the hard subsystem
  output logic memory_controller_clock,
  output logic apb_clock,
  // Link
  fac_link_if.dev link
);

  // ========================================================
  // State
  typedef struct packed {
    logic [11:0] cnt;              // Common tick counter
    logic [CK_NUM-1:0][11:0] ph;   // Phase of each derived clock
    logic [CK_NUM-1:0] ck;         // Level of each derived clock
    logic [31:0] cfg1;             // Config register 1
    logic [31:0] cfg2;             // Config register 2, no status
    logic [31:0] prot1;            // Write protect mask, reg 1
    logic [31:0] prot2;            // Write protect mask, reg 2
    logic [31:0] act1;             // Ratio codes in force, reg 1
    logic [31:0] act2;             // Ratio codes in force, reg 2
    logic loaded;                  // Flash image has been taken
    logic lock;                    // Exported clock valid
    logic align;                   // Phase 0 of all clocks
    logic base_prev;               // Base clock one tick ago
    logic align_err;               // Sticky base alignment error
    logic ack;                     // Register answer strobe
    logic [31:0] rdata;            // Register read data
  } fac_dev_s;

  fac_dev_s st_reg;
  fac_dev_s st_next;
  logic [CK_NUM-1:0][11:0] per;    // Period of each clock in ticks
  logic wrap;                      // Counter at its last tick
  logic hit1;                      // Address is config register 1
  logic hit2;                      // Address is config register 2
  logic wr1;                       // Write to config register 1
  logic wr2;                       // Write to config register 2
  logic base_bad;                  // Base clock not rising at mark
  logic [31:0] stat2;              // Register 2 as read back

  // ========================================================
  // Next state
  always_comb begin
    st_next = st_reg;

    // Common counter; every period divides its length R14
    wrap = st_reg.cnt == WRAP_LAST;
    st_next.cnt = wrap ? 12'h000 : st_reg.cnt + 12'h001;
    st_next.align = wrap;

    // Stored codes take effect only at the common phase 0, so a
    // change never leaves a runt or stray rising edge behind R14
    if (wrap) begin
      st_next.act1 = st_reg.cfg1;
      st_next.act2 = st_reg.cfg2;
    end

    // Periods from the ratio codes in force
    // Main clock is the bus matrix, DMA and memory clock R1
    per[CK_MAIN] = MAIN_PER;
    // Memory controller clock is a multiple of main R2
    per[CK_MC] = fac_mc_per(st_reg.act1[MC_MULT_LSB +: 3]);
    // Memory fabric clock divides the controller clock R3
    per[CK_MF] = 12'(per[CK_MC] *
                     fac_mf_div(st_reg.act1[MF_DIV_LSB +: 3]));
    // Two interface clocks, main divided by 1..32 R4
    per[CK_IF0] = fac_ratio_per(st_reg.act2[IF0_DIV_LSB +: 3]);
    per[CK_IF1] = fac_ratio_per(st_reg.act2[IF1_DIV_LSB +: 3]);
    // Peripheral bus clock from main R6
    per[CK_APB] = fac_ratio_per(st_reg.act1[APB_DIV_LSB +: 3]);

    // All phases restart together, so every rise is aligned R14
    for (int i = 0; i < CK_NUM; i++) begin
      if (wrap) begin
        st_next.ph[i] = 12'h000;
      end else begin
        st_next.ph[i] = fac_step(st_reg.ph[i], per[i]);
      end
      st_next.ck[i] = fac_level(st_next.ph[i], per[i]);
    end

    // Address decode on the full system address R13
    hit1 = reg_addr == SYSTEM_REGISTER_BLOCK_BASE + CFG1_OFS;
    hit2 = reg_addr == SYSTEM_REGISTER_BLOCK_BASE + CFG2_OFS;
    wr1 = reg_req && reg_we && hit1;
    wr2 = reg_req && reg_we && hit2;

    // Register 2 carries lock and error status R12
    stat2 = st_reg.cfg2;
    stat2[LOCK_BIT] = st_reg.lock;
    stat2[ALIGN_ERR_BIT] = st_reg.align_err;

    // Reads answer one tick later; unmapped reads give zero R12
    st_next.ack = reg_req;
    if (reg_req && !reg_we && hit1) begin
      st_next.rdata = st_reg.cfg1;
    end else if (reg_req && !reg_we && hit2) begin
      st_next.rdata = stat2;
    end else begin
      st_next.rdata = 32'h00000000;
    end

    // Run-time writes touch only unprotected fields R11 R15
    if (wr1) begin
      st_next.cfg1 = (st_reg.cfg1 & st_reg.prot1) |
                     (reg_wdata & ~st_reg.prot1);
    end
    if (wr2) begin
      st_next.cfg2 = ((st_reg.cfg2 & st_reg.prot2) |
                      (reg_wdata & ~st_reg.prot2)) & ~CFG2_STATUS;
    end

    // Static start-up load from flash R11
    if (flash_load) begin
      st_next.cfg1 = flash_cfg1;
      st_next.cfg2 = flash_cfg2 & ~CFG2_STATUS;
      st_next.prot1 = flash_prot1;
      st_next.prot2 = flash_prot2;
      st_next.loaded = 1'b1;
    end

    // Lock drops on any config change and returns at the next
    // common phase 0, when the new ratios are in step R10
    if (flash_load || wr1 || wr2) begin
      st_next.lock = 1'b0;
    end else if (wrap && st_reg.loaded) begin
      st_next.lock = 1'b1;
    end

    // Base clock must rise at the common mark while locked R8
    st_next.base_prev = link.base_sync_clock;
    base_bad = st_reg.lock && st_reg.align &&
               !(link.base_sync_clock && !st_reg.base_prev);
    // Write one to clear; a new error in the same tick wins
    if (wr2 && reg_wdata[ALIGN_ERR_BIT]) begin
      st_next.align_err = base_bad;
    end else begin
      st_next.align_err = st_reg.align_err || base_bad;
    end
  end

  // ========================================================
  // Registers, loaded with their reset values by the system register reset R15
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.cfg1 <= CFG_RESET;
      st_reg.cfg2 <= CFG_RESET;
      st_reg.prot1 <= PROT_RESET;
      st_reg.prot2 <= PROT_RESET;
      // Start one tick before the mark, so the first rise is whole
      st_reg.cnt <= WRAP_LAST;
      st_reg.ph <= {CK_NUM{MAIN_PER - 12'h001}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================
  // Outputs straight from flip-flops
  assign reg_ack = st_reg.ack;
  assign reg_rdata = st_reg.rdata;
  assign memory_controller_clock = st_reg.ck[CK_MC];
  assign apb_clock = st_reg.ck[CK_APB];
  assign link.main_subsystem_clock = st_reg.ck[CK_MAIN];
  assign link.memory_fabric_if_clock = st_reg.ck[CK_MF];
  assign link.fabric_if0_clock = st_reg.ck[CK_IF0];
  assign link.exported_if1_clock = st_reg.ck[CK_IF1];
  assign link.exported_if1_lock = st_reg.lock;
  assign link.align_mark = st_reg.align;

endmodule

//--- sim/fac_props.sv
`timescale 1ns/1ps
// ==========================================================
// Link checker, watching both ends from outside
module fac_props
  import fac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link signals
  input wire logic main_subsystem_clock,
  input wire logic memory_fabric_if_clock,
  input wire logic fabric_if0_clock,
  input wire logic exported_if1_clock,
  input wire logic exported_if1_lock,
  input wire logic align_mark,
  input wire logic base_sync_clock
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ========================================================
  // Cycles since the last mark; the first mark has no gap yet
  logic [11:0] gap_reg;
  logic seen_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_reg <= 12'h000;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= align_mark ? 12'h000 : gap_reg + 12'h001;
      seen_reg <= seen_reg | align_mark;
    end
  end

  // Main clock: high for half its 24 ticks, then low
  sequence s_main_half;
    ##11 main_subsystem_clock ##1 !main_subsystem_clock;
  endsequence
  // Next rise exactly one main period later
  sequence s_main_next;
    ##24 $rose(main_subsystem_clock);
  endsequence

  // ========================================================
  // Properties
  a_mark_all_high: assert property (
    align_mark |-> main_subsystem_clock && memory_fabric_if_clock
      && fabric_if0_clock && exported_if1_clock)
    else $error("clock low at alignment mark");
  a_main_half: assert property (
    align_mark |-> s_main_half)
    else $error("main clock duty wrong");
  a_main_period: assert property (
    $rose(main_subsystem_clock) |-> s_main_next)
    else $error("main clock period wrong");
  a_mark_gap: assert property (
    align_mark && seen_reg |-> gap_reg == WRAP_LAST)
    else $error("alignment mark spacing wrong");
  a_lock_on_mark: assert property (
    $rose(exported_if1_lock) |-> align_mark)
    else $error("lock rose away from phase zero");
  a_base_rises: assert property (
    align_mark && exported_if1_lock
      |-> base_sync_clock && !$past(base_sync_clock))
    else $error("base clock not rising at mark");
  a_if0_on_main: assert property (
    $rose(fabric_if0_clock) |-> $rose(main_subsystem_clock))
    else $error("interface 0 clock off main edge");
  a_if1_on_main: assert property (
    $rose(exported_if1_clock) |-> $rose(main_subsystem_clock))
    else $error("interface 1 clock off main edge");
endmodule

//--- sim/fabric_interface_clock_ratios_bench.sv
`timescale 1ns/1ps
// ==========================================================
// Bench: both ends joined by the link, model of the ratios
module fabric_interface_clock_ratios_bench;
  import fac_pkg::*;
  // Stimulus, all given a value at time zero
  logic clk = 1'b0, sys_rst = 1'b1, ld = 1'b0, rq = 1'b0;
  logic we = 1'b0;
  logic [31:0] c1 = '0, c2 = '0, p1 = '0, p2 = '0;
  logic [31:0] ad = '0, wd = '0, rd, q;
  logic [2:0] s0 = '0, s1 = '0;
  logic ack, mcc, apc, k0, k1, ul;
  wire [5:0] cks;
  // Model tables and counters
  int fail_count = 0, tests_run = 0;
  int ex[6], got[6];
  int mul[6] = '{1, 2, 3, 4, 6, 8};
  int dv[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
  localparam logic [31:0] ADR1 = SYSTEM_REGISTER_BLOCK_BASE + CFG1_OFS;
  localparam logic [31:0] ADR2 = SYSTEM_REGISTER_BLOCK_BASE + CFG2_OFS;

  fac_link_if lk();
  fac_clock_ctrl fac_clock_ctrl_i(.clk(clk), .sys_rst(sys_rst),
    .flash_load(ld), .flash_cfg1(c1), .flash_cfg2(c2),
    .flash_prot1(p1), .flash_prot2(p2), .reg_req(rq), .reg_we(we),
    .reg_addr(ad), .reg_wdata(wd), .reg_ack(ack), .reg_rdata(rd),
    .memory_controller_clock(mcc), .apb_clock(apc), .link(lk));
  fac_fabric_end fac_fabric_end_i(.clk(clk), .sys_rst(sys_rst),
    .sub0_sel(s0), .sub1_sel(s1), .sub0_clock(k0),
    .sub1_clock(k1), .user_lock(ul), .link(lk));
  fac_props fac_props_i(.clk(clk), .sys_rst(sys_rst),
    .main_subsystem_clock(lk.main_subsystem_clock),
    .memory_fabric_if_clock(lk.memory_fabric_if_clock),
    .fabric_if0_clock(lk.fabric_if0_clock),
    .exported_if1_clock(lk.exported_if1_clock),
    .exported_if1_lock(lk.exported_if1_lock),
    .align_mark(lk.align_mark), .base_sync_clock(lk.base_sync_clock));
  // Slots: main, mc, mf, if0, if1, apb
  assign cks = {apc, lk.exported_if1_clock, lk.fabric_if0_clock,
                lk.memory_fabric_if_clock, mcc, lk.main_subsystem_clock};

  // ========================================================
  // Clock, 200 MHz
  initial begin
    forever #2.5 clk = ~clk;
  end

  // ========================================================
  // Verdict and compares
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cr(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cp(input int g, input int e);
    tests_run++;
    if (g != e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Register access: ack must come exactly one cycle after req
  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    rq <= 1'b1;
    we <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    rq <= 1'b0;
    @(posedge clk);
    cr({31'h0, ack}, 32'h1);
    q = rd;
  endtask

  // ========================================================
  // One configuration: load, wait for phase zero, measure
  task automatic run(input int i);
    logic [2:0] a0, a1, m, ap;
    logic [5:0] pv;
    logic pl;
    int n;
    m = 3'(i % 6);
    ap = 3'($urandom % 6);
    a0 = 3'($urandom % 6);
    a1 = 3'((i + 3) % 6);
    @(posedge clk);
    c1 <= {21'h0, ap, 1'b0, 3'(i), 1'b0, m};
    // Status bits set in the image must never be stored
    c2 <= {2'b11, 22'($urandom), 1'b0, a1, 1'b0, a0};
    p1 <= 32'hFFFFF8FF;
    p2 <= 32'hFFFFFFFF;
    s0 <= a0;
    s1 <= a1;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    // Expected periods in ticks
    ex[0] = 24;
    ex[1] = 24 / mul[m];
    ex[2] = ex[1] * dv[i];
    ex[3] = 24 << a0;
    ex[4] = 24 << a1;
    ex[5] = 24 << ap;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (lk.align_mark !== 1'b1 && n < 2400);
    cr({31'h0, lk.exported_if1_lock}, 32'h1);
    got = '{default: 0};
    pv = cks;
    pl = lk.exported_if1_lock;
    // Longest period is 768 ticks, so 800 covers every rise
    for (n = 1; n <= 800; n++) begin
      @(posedge clk);
      foreach (got[k]) begin
        if (got[k] == 0 && cks[k] === 1'b1 && pv[k] === 1'b0) begin
          got[k] = n;
        end
      end
      pv = cks;
      if (n > 1) begin
        cr({29'h0, ul, k1, k0}, {29'h0, pl, lk.exported_if1_clock,
           lk.fabric_if0_clock});
      end
      pl = lk.exported_if1_lock;
    end
    foreach (ex[k]) cp(got[k], ex[k]);
    acc(1'b0, ADR1, '0);
    cr(q, c1);
    acc(1'b0, ADR2, '0);
    cr(q, {2'b10, c2[29:0]});
    // Fully protected write keeps the value; any write drops lock
    acc(1'b1, ADR2, '1);
    acc(1'b0, ADR2, '0);
    cr(q, {2'b00, c2[29:0]});
    // Only the peripheral ratio field is writable; lock drops
    acc(1'b1, ADR1, '1);
    acc(1'b0, ADR1, '0);
    cr(q, c1 | 32'h00000700);
    acc(1'b0, ADR2, '0);
    cr(q, {2'b00, c2[29:0]});
    acc(1'b0, SYSTEM_REGISTER_BLOCK_BASE + 32'h000000A0, '0);
    cr(q, 32'h0);
  endtask

  // ========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hA5C8));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    acc(1'b0, ADR1, '0);
    cr(q, CFG_RESET);
    acc(1'b0, ADR2, '0);
    cr(q, CFG_RESET);
    for (int i = 0; i < 8; i++) begin
      run(i);
    end
    stop_test();
  end

  // Watchdog: the run needs about 19300 cycles
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule
